// File: logic/fci_ctrl.sv
// Operation
// - unlocked commands execute only after complete three, four or six write-cycle sequences.
// - cycle one, and cycle four of an erase, carry one fixed unlock code; cycle two, and cycle five of an erase, another.
// - instruction code in cycle three, erase confirm code in cycle six.
// - program: target address and data byte go in write cycle four.
// - erase: second unlock in cycles four and five, confirm in cycle six.
// - address taken on write strobe fall, data on rise; host holds both.
module fci_ctrl
    import fci_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [AVS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [DATA_W-1:0] flash_dq_in,
    output fci_pins_t flash_out
);

    fci_state_t state;
    fci_cmd_t cmd;
    logic [ADDR_W-1:0] target_addr;
    logic [DATA_W-1:0] write_byte;
    logic [DATA_W-1:0] last_byte;
    logic [DATA_W-1:0] prev_poll;
    logic [2:0] step;
    logic first_poll;
    logic err_seen;
    logic done_flag;
    logic fail_flag;
    logic ack;
    logic wr_ok;
    logic start;
    logic cyc_start;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic [DATA_W-1:0] dq_sync;
    fci_cyc_req_t cyc_req;
    logic last_step;
    logic needs_poll;

    // ==========================================
    // sequence tables
    function automatic logic [2:0] seq_last(input fci_cmd_t c);
        case (c)
            FCI_CMD_RESET, FCI_CMD_POWER_DOWN: seq_last = 3'd2;
            FCI_CMD_READ_ID, FCI_CMD_READ_PROT, FCI_CMD_PROGRAM: seq_last = 3'd3;
            FCI_CMD_BLOCK_ERASE, FCI_CMD_CHIP_ERASE: seq_last = 3'd5;
            default: seq_last = 3'd0;
        endcase
    endfunction

    function automatic fci_cyc_req_t seq_step(input fci_cmd_t c, input logic [2:0] idx,
                                              input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        fci_cyc_req_t r;
        r = '{write: 1'b1, id_voltage_drive: 1'b0, addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
        case (c)
            FCI_CMD_READ: begin
                r.write = 1'b0;
                r.addr = a;
            end
            FCI_CMD_HV_READ: begin
                r.write = 1'b0;
                r.id_voltage_drive = 1'b1;
                r.addr = a;
            end
            FCI_CMD_SUSPEND: begin
                r.addr = a;
                r.data = CODE_SUSPEND;
            end
            FCI_CMD_RESUME: begin
                r.addr = a;
                r.data = CODE_RESUME;
            end
            default: begin
                case (idx)
                    3'd0, 3'd3: begin
                        r.addr = UNLOCK_ADDR1;
                        r.data = UNLOCK_DATA1;
                    end
                    3'd1, 3'd4: begin
                        r.addr = UNLOCK_ADDR2;
                        r.data = UNLOCK_DATA2;
                    end
                    3'd2: begin
                        r.addr = UNLOCK_ADDR1;
                        case (c)
                            FCI_CMD_RESET: r.data = CODE_RESET;
                            FCI_CMD_READ_ID, FCI_CMD_READ_PROT: r.data = CODE_SIGNATURE;
                            FCI_CMD_PROGRAM: r.data = CODE_PROGRAM;
                            FCI_CMD_POWER_DOWN: r.data = CODE_POWER_DOWN;
                            default: r.data = CODE_ERASE_SETUP;
                        endcase
                    end
                    default: begin
                        r.addr = a;
                        r.data = CODE_BLOCK_CONFIRM;
                        if (c == FCI_CMD_CHIP_ERASE) begin
                            r.addr = UNLOCK_ADDR1;
                            r.data = CODE_CHIP_CONFIRM;
                        end
                    end
                endcase
                if (idx == 3'd3) begin
                    if (c == FCI_CMD_PROGRAM) begin
                        r.addr = a;
                        r.data = d;
                    end else if (c == FCI_CMD_READ_ID || c == FCI_CMD_READ_PROT) begin
                        r.write = 1'b0;
                        r.addr = a;
                    end
                end
            end
        endcase
        seq_step = r;
    endfunction

    // ==========================================
    // avalon slave
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;
    assign wr_ok = avs_write_in && ack;
    assign start = wr_ok && (avs_address_in == REG_CTRL) && avs_byteenable_in[0] && (state == ST_IDLE)
                   && (avs_writedata_in[3:0] <= 4'(FCI_CMD_HV_READ));

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_in || avs_write_in) && !ack;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !ack) begin
            avs_readdata_out <= 32'h0000_0000;
            case (avs_address_in)
                REG_CTRL: avs_readdata_out[3:0] <= cmd;
                REG_ADDR: avs_readdata_out[ADDR_W-1:0] <= target_addr;
                REG_WDATA: avs_readdata_out[DATA_W-1:0] <= write_byte;
                REG_STATUS: begin
                    avs_readdata_out[ST_BUSY] <= (state != ST_IDLE);
                    avs_readdata_out[ST_DONE] <= done_flag;
                    avs_readdata_out[ST_FAIL] <= fail_flag;
                    avs_readdata_out[ST_BYTE_LSB +: DATA_W] <= last_byte;
                end
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmd <= fci_cmd_t'(CTRL_RESET_VAL);
        end else if (start) begin
            cmd <= fci_cmd_t'(avs_writedata_in[3:0]);
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            target_addr <= ADDR_RESET_VAL;
        end else if (wr_ok && (avs_address_in == REG_ADDR) && (state == ST_IDLE)) begin
            if (avs_byteenable_in[0]) target_addr[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1]) target_addr[15:8] <= avs_writedata_in[15:8];
            if (avs_byteenable_in[2]) target_addr[18:16] <= avs_writedata_in[18:16];
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            write_byte <= DATA_RESET_VAL;
        end else if (wr_ok && (avs_address_in == REG_WDATA) && avs_byteenable_in[0] && (state == ST_IDLE)) begin
            write_byte <= avs_writedata_in[7:0];
        end
    end

    // ==========================================
    // command sequencer and completion polling
    assign last_step = (step == seq_last(cmd));
    assign needs_poll = (cmd == FCI_CMD_PROGRAM) || (cmd == FCI_CMD_BLOCK_ERASE) || (cmd == FCI_CMD_CHIP_ERASE);
    assign cyc_start = (state == ST_ISSUE) || (state == ST_POLL);

    always_comb begin
        cyc_req = seq_step(cmd, step, target_addr, write_byte);
        if (state == ST_POLL) begin
            cyc_req = '{write: 1'b0, id_voltage_drive: 1'b0, addr: target_addr, data: DATA_RESET_VAL};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            step <= 3'd0;
            first_poll <= 1'b0;
            err_seen <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        step <= 3'd0;
                        err_seen <= 1'b0;
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: state <= ST_WAIT;
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (!last_step) begin
                            step <= step + 3'd1;
                            state <= ST_ISSUE;
                        end else if (needs_poll) begin
                            first_poll <= 1'b1;
                            state <= ST_POLL;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_POLL: state <= ST_POLL_WAIT;
                ST_POLL_WAIT: begin
                    if (cyc_done) begin
                        first_poll <= 1'b0;
                        if (first_poll) begin
                            state <= ST_POLL;
                        end else if (cyc_rdata[TOGGLE_BIT] == prev_poll[TOGGLE_BIT]) begin
                            state <= ST_IDLE;
                        end else if (err_seen) begin
                            state <= ST_IDLE;
                        end else begin
                            err_seen <= cyc_rdata[ERROR_BIT];
                            state <= ST_POLL;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prev_poll <= DATA_RESET_VAL;
            last_byte <= DATA_RESET_VAL;
        end else if (cyc_done && ((state == ST_POLL_WAIT) || !cyc_req.write)) begin
            prev_poll <= cyc_rdata;
            last_byte <= cyc_rdata;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else if (start) begin
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else if ((state == ST_WAIT) && cyc_done && last_step && !needs_poll) begin
            done_flag <= 1'b1;
        end else if ((state == ST_POLL_WAIT) && cyc_done && !first_poll) begin
            if (cyc_rdata[TOGGLE_BIT] == prev_poll[TOGGLE_BIT]) begin
                done_flag <= 1'b1;
            end else if (err_seen) begin
                done_flag <= 1'b1;
                fail_flag <= 1'b1;
            end
        end
    end

    // ==========================================
    // pin side
    fci_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in(flash_dq_in),
        .sync_out(dq_sync)
    );

    fci_bus_cycle u_cycle (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .start_in(cyc_start),
        .req_in(cyc_req),
        .dq_sync_in(dq_sync),
        .pins_out(flash_out),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata)
    );

endmodule

// File: logic/fci_pkg.sv
package fci_pkg;

    // ==========================================
    // widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int AVS_ADDR_W = 5;

    // ==========================================
    // clock and pin timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_SETUP_NS = 25;
    localparam int T_PULSE_NS = 50;
    localparam int T_ACCESS_NS = 150;
    localparam int T_HOLD_NS = 25;
    localparam int SYNC_LAT = 3;
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // pins lag the state by one edge and the sync output adds one more
    localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT + 2);
    localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================
    // command sequence codes
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h0_5555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h0_2AAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [DATA_W-1:0] CODE_RESET = 8'hF0;
    localparam logic [DATA_W-1:0] CODE_SIGNATURE = 8'h90;
    localparam logic [DATA_W-1:0] CODE_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CODE_BLOCK_CONFIRM = 8'h30;
    localparam logic [DATA_W-1:0] CODE_CHIP_CONFIRM = 8'h10;
    localparam logic [DATA_W-1:0] CODE_SUSPEND = 8'hB0;
    localparam logic [DATA_W-1:0] CODE_RESUME = 8'h30;
    localparam logic [DATA_W-1:0] CODE_POWER_DOWN = 8'hB8;

    // ==========================================
    // status bit positions on the data bus
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int ERROR_BIT = 5;
    localparam int ERASE_TIMER_BIT = 3;

    // ==========================================
    // register map, byte offsets
    localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [AVS_ADDR_W-1:0] REG_ADDR = 5'h04;
    localparam logic [AVS_ADDR_W-1:0] REG_WDATA = 5'h08;
    localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 5'h0C;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_BYTE_LSB = 8;
    localparam logic [3:0] CTRL_RESET_VAL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET_VAL = 19'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RESET_VAL = 8'h00;

    // ==========================================
    // types
    typedef enum logic [3:0] {
        FCI_CMD_READ, FCI_CMD_RESET, FCI_CMD_READ_ID, FCI_CMD_READ_PROT, FCI_CMD_PROGRAM,
        FCI_CMD_BLOCK_ERASE, FCI_CMD_CHIP_ERASE, FCI_CMD_SUSPEND, FCI_CMD_RESUME,
        FCI_CMD_POWER_DOWN, FCI_CMD_HV_READ
    } fci_cmd_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_POLL_WAIT} fci_state_t;

    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fci_cyc_state_t;

    typedef struct packed {
        logic write;
        logic id_voltage_drive;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fci_cyc_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic id_voltage_drive;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fci_pins_t;

endpackage

// File: logic/fci_sync.sv
module fci_sync
    import fci_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [DATA_W-1:0] async_in,
    output logic [DATA_W-1:0] sync_out
);

    logic [DATA_W-1:0] stage1;
    logic [DATA_W-1:0] stage2;
    logic [DATA_W-1:0] stage3;

    // ==========================================
    // three stages, a bit changes once stages two and three agree
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1 <= DATA_RESET_VAL;
            stage2 <= DATA_RESET_VAL;
            stage3 <= DATA_RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_out <= DATA_RESET_VAL;
        end else begin
            sync_out <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & sync_out);
        end
    end

endmodule

// File: logic/fci_bus_cycle.sv
module fci_bus_cycle
    import fci_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire fci_cyc_req_t req_in,
    input wire logic [DATA_W-1:0] dq_sync_in,
    output fci_pins_t pins_out,
    output logic done_out,
    output logic [DATA_W-1:0] rdata_out
);

    fci_cyc_state_t state;
    fci_cyc_req_t req;
    logic [3:0] cnt;

    // ==========================================
    // cycle sequencing: setup, strobe, hold
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= CY_IDLE;
            cnt <= 4'h0;
            req <= '0;
        end else begin
            case (state)
                CY_IDLE: begin
                    if (start_in) begin
                        req <= req_in;
                        cnt <= SETUP_CYC;
                        state <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (cnt <= 4'h1) begin
                        cnt <= req.write ? PULSE_CYC : ACCESS_CYC;
                        state <= CY_STROBE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                CY_STROBE: begin
                    if (cnt <= 4'h1) begin
                        cnt <= HOLD_CYC;
                        state <= CY_HOLD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                CY_HOLD: begin
                    if (cnt <= 4'h1) begin
                        state <= CY_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: state <= CY_IDLE;
            endcase
        end
    end

    assign done_out = (state == CY_HOLD) && (cnt <= 4'h1);

    // ==========================================
    // pin drive, one cycle behind the state
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, id_voltage_drive: 1'b0,
                          addr: ADDR_RESET_VAL, dq_out: DATA_RESET_VAL, dq_oe: 1'b0};
        end else begin
            pins_out.ce_n <= (state == CY_IDLE);
            pins_out.we_n <= !((state == CY_STROBE) && req.write);
            pins_out.oe_n <= !((state == CY_STROBE) && !req.write);
            pins_out.id_voltage_drive <= (state != CY_IDLE) && req.id_voltage_drive;
            pins_out.addr <= req.addr;
            pins_out.dq_out <= req.data;
            pins_out.dq_oe <= (state != CY_IDLE) && req.write;
        end
    end

    // ==========================================
    // read data taken at the end of the strobe
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= DATA_RESET_VAL;
        end else if ((state == CY_STROBE) && (cnt <= 4'h1) && !req.write) begin
            rdata_out <= dq_sync_in;
        end
    end

endmodule

// File: sim/fci_ctrl_props.sv
module fci_ctrl_props
    import fci_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire fci_pins_t flash_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ==========================================
    // bus and pin relations
    a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("wait too long");
    a_strobe_excl: assert property (flash_out.oe_n || flash_out.we_n)
        else $error("both strobes low");
    a_strobe_select: assert property (!(flash_out.oe_n && flash_out.we_n) |-> !flash_out.ce_n)
        else $error("strobe without select");
    a_write_drive: assert property (!flash_out.we_n |-> flash_out.dq_oe)
        else $error("write not driven");
    a_read_float: assert property (!flash_out.oe_n |-> !flash_out.dq_oe)
        else $error("read contended");
    a_we_width: assert property ($fell(flash_out.we_n) |=> !flash_out.we_n ##1 flash_out.we_n)
        else $error("strobe width");
    a_latch_hold: assert property ($rose(flash_out.we_n) |-> $stable({flash_out.addr, flash_out.dq_out}))
        else $error("latch not held");
    a_id_read: assert property (flash_out.id_voltage_drive |-> flash_out.we_n)
        else $error("write under id voltage");
endmodule

// File: sim/fci_flash_model.sv
module fci_flash_model
    import fci_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC4, // arbitrary value
    parameter logic [7:0] PROT_MAP = 8'h04,
    parameter int PROG_NS = 2000, // scaled down for short runs
    parameter int ERASE_NS = 4000
)
(
    input wire fci_pins_t pins_in,
    output logic [DATA_W-1:0] dq_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    logic [ADDR_W-1:0] la;
    logic [7:0] rv = 8'h00;
    logic [7:0] pdat = 8'hFF;
    logic [7:0] cmd = 8'h00;
    logic idm = 1'h0;
    logic tog = 1'h0;
    logic errq = 1'h0;
    logic vis = 1'h0;
    logic ers = 1'h0;
    int n = 0;
    int acc = 0;
    time done_t = 0;
    time left = 0;
    function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
        if ($time < done_t) return {ers ? 1'h0 : ~pdat[7], tog, errq, 5'h00};
        if (idm || pins_in.id_voltage_drive)
            return a[1] ? {7'h00, PROT_MAP[a[18:16]]} : (a[0] ? PART_CODE : MAKER_CODE);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    always @(negedge pins_in.oe_n) begin
        if (!pins_in.ce_n) begin
            if ($time < done_t) tog = ~tog;
            rv = rd(pins_in.addr);
            #(acc) vis = 1'h1;
        end
    end
    always @(posedge pins_in.oe_n) vis = 1'h0;
    assign dq_level_out = pins_in.dq_oe ? pins_in.dq_out : ((vis && !pins_in.ce_n) ? rv : ~rv);
    always @(negedge pins_in.we_n) la = pins_in.addr;
    always @(posedge pins_in.we_n) begin
        if (!pins_in.ce_n) step(la, dq_level_out);
    end
    task automatic step(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic u2;
        u2 = (n == 1 || n == 4);
        if (n == 0 && ers && d == CODE_SUSPEND && $time < done_t) begin
            left = done_t - $time;
            done_t = 0;
        end else if (n == 0 && d == CODE_RESUME && left != 0) begin
            done_t = $time + left;
            left = 0;
        end
        if (d == CODE_RESET && n != 3) begin
            errq = 1'h0;
            done_t = 0;
        end
        if (n == 2) begin
            cmd = d;
            idm = (d == CODE_SIGNATURE);
            n = (d == CODE_PROGRAM || d == CODE_ERASE_SETUP) ? 3 : 0;
        end else if (n == 3 && cmd == CODE_PROGRAM) begin
            n = 0;
            pdat = d;
            ers = 1'h0;
            errq = PROT_MAP[a[18:16]];
            if (!errq) mem[a] = d;
            done_t = errq ? 64'h7FFF_FFFF_FFFF_FFFF : $time + PROG_NS;
        end else if (n == 5) begin
            n = 0;
            ers = 1'h1;
            foreach (mem[k]) if (!PROT_MAP[k[18:16]] && (d == CODE_CHIP_CONFIRM || k[18:16] == a[18:16])) mem[k] = 8'hFF;
            done_t = $time + ERASE_NS;
        end else begin
            n = (a == (u2 ? UNLOCK_ADDR2 : UNLOCK_ADDR1) && d == (u2 ? UNLOCK_DATA2 : UNLOCK_DATA1)) ? n + 1 : 0;
            if (n == 0) idm = 1'h0;
        end
    endtask
endmodule

// File: sim/tb.sv
module tb import fci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic wait_rq;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] st;
    logic [7:0] dq;
    fci_pins_t pins;
    int failures = 0;
    int num_checks = 0;
    fci_ctrl uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_rq), .flash_dq_in(dq), .flash_out(pins));
    fci_flash_model #(.MAKER_CODE(8'h5A), .PART_CODE(8'hC4)) dev (.pins_in(pins), .dq_level_out(dq));
    always #12.5 sys_clk_in = ~sys_clk_in;
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do @(posedge sys_clk_in); while (wait_rq !== 1'h0);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
        bus(1'h1, REG_ADDR, {13'h0000, a}, st);
        bus(1'h1, REG_WDATA, {24'h00_0000, d}, st);
        bus(1'h1, REG_CTRL, {28'h000_0000, c}, st);
        do bus(1'h0, REG_STATUS, 32'h0000_0000, st); while (st[ST_BUSY] !== 1'h0);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        failures++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        reset_n_in <= 1'h1;
        bus(1'h0, REG_STATUS, 32'h0000_0000, st);
        chk(st, 32'h0000_0000);
        bus(1'h0, 5'h10, 32'h0000_0000, st);
        chk(st, 32'h0000_0000);
        run(4'h4, 19'h1_2345, 8'h3C);
        chk(st[2:0], 3'h2);
        run(4'h0, 19'h1_2345, 8'h00);
        chk(st[15:8], 8'h3C);
        run(4'h2, 19'h0_0000, 8'h00);
        chk(st[15:8], 8'h5A);
        run(4'h2, 19'h0_0001, 8'h00);
        chk(st[15:8], 8'hC4);
        run(4'h3, 19'h2_0002, 8'h00);
        chk(st[15:8], 8'h01);
        run(4'h3, 19'h3_0002, 8'h00);
        chk(st[15:8], 8'h00);
        run(4'h1, 19'h0_0000, 8'h00);
        dev.acc = 125;
        run(4'hA, 19'h0_0001, 8'h00);
        chk(st[15:8], 8'hC4);
        run(4'h1, 19'h0_0000, 8'h00);
        run(4'h4, 19'h2_0010, 8'h3C);
        chk(st[2:0], 3'h6);
        run(4'h1, 19'h0_0000, 8'h00);
        chk(st[2:0], 3'h2);
        run(4'h5, 19'h1_0000, 8'h00);
        chk(st[2:0], 3'h2);
        run(4'h0, 19'h1_2345, 8'h00);
        chk(st[15:8], 8'hFF);
        run(4'h4, 19'h4_0100, 8'hA5);
        run(4'h6, 19'h0_0000, 8'h00);
        run(4'h0, 19'h4_0100, 8'h00);
        chk(st[15:8], 8'hFF);
        for (int c = 7; c <= 9; c++) begin
            run(4'(c), 19'h0_0000, 8'h00);
            chk(st[2:0], 3'h2);
        end
        final_report();
    end
endmodule
bind fci_ctrl fci_ctrl_props props (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .flash_out(flash_out));
